/* eag_effective_address_generator.v */
// effective, physical, port and string address generation for the core
`timescale 1ns/10ps
`default_nettype none
`include "eag_defs.vh"

// Behaviour
// - physical address is offset plus shifted segment, twenty bits wide
// - offset is an unsigned sixteen-bit byte distance into the segment
// - addressing-mode byte decides how each memory offset is formed
// - offset sums displacement, base and index; any subset may appear
// - displacement is an eight- or sixteen-bit constant from the instruction
// - base is general base or frame pointer; index is source or dest index
// - frame-pointer base defaults to stack segment; override may change it
// - direct mode uses no register: offset equals displacement
// - register indirect uses base or index; jumps accept any general register
// - based mode adds displacement to general base or frame pointer
// - indexed mode adds displacement to source or destination index
// - based index mode adds base, index and displacement
// - strings use source index in data segment or the override segment, dest index in extra segment
// - string operations update both index registers to the next element
// - direct port number is an eight-bit immediate, ports 0 to 255
// - indirect port number comes from the port number register, to 65535
// - immediates are eight or sixteen bits, no bus cycle, source only
// - register-only operations start no bus cycle
// - memory operands run one or more bus cycles at the physical address
// - signed byte and word operands are two's complement
// - packed decimal byte holds one digit in each nibble
// - a 32-bit pointer splits into segment selector and offset halves
// - direction flag clear increments the indices, set decrements them
// - indices step by one for bytes and by two for words
module eag_effective_address_generator #(
	parameter OFS_W = 16,
	parameter PHY_W = 20
) (
	input  wire              clk_in,
	input  wire              rst_n_in,
	input  wire              req_in,
	input  wire [2:0]        op_kind_in,
	input  wire [7:0]        mode_byte_in,
	input  wire [7:0]        disp_lo_in,
	input  wire [7:0]        disp_hi_in,
	input  wire              word_in,
	input  wire              jump_instruction_in,
	input  wire [127:0]      gen_regs_in,
	input  wire [15:0]       extra_segment_register_in,
	input  wire [15:0]       code_segment_in,
	input  wire [15:0]       stack_segment_in,
	input  wire [15:0]       data_segment_register_in,
	input  wire              seg_override_in,
	input  wire [1:0]        seg_override_sel_in,
	input  wire              direction_flag_in,
	input  wire [15:0]       operand_data_in,
	input  wire [31:0]       pointer_data_in,
	output wire              done_out,
	output wire [OFS_W-1:0]  operand_offset_out,
	output wire [PHY_W-1:0]  phys_addr_out,
	output wire [1:0]        seg_sel_out,
	output wire              mem_cycle_req_out,
	output wire [1:0]        mem_cycle_count_out,
	output wire              reg_only_out,
	output wire [15:0]       jump_target_out,
	output wire              imm_valid_out,
	output wire [15:0]       imm_value_out,
	output wire              io_req_out,
	output wire [15:0]       io_port_out,
	output wire              str_valid_out,
	output wire [PHY_W-1:0]  str_src_phys_out,
	output wire [PHY_W-1:0]  str_dst_phys_out,
	output wire [15:0]       src_index_next_out,
	output wire [15:0]       destination_index_register_next_out,
	output wire [15:0]       signed_operand_out,
	output wire [3:0]        bcd_high_digit_out,
	output wire [3:0]        bcd_low_digit_out,
	output wire [15:0]       ptr_selector_out,
	output wire [15:0]       ptr_offset_out
);

	// reset release synchroniser
	reg        rst_meta_ff;
	reg        rst_sync_ff;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// unpack the eight general registers
	wire [15:0] gen_reg [0:7];
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_regs
			assign gen_reg[gi] = gen_regs_in[gi*16 +: 16];
		end
	endgenerate

	wire [15:0] general_base_register      = gen_reg[`EAG_REG_BASE];
	wire [15:0] stack_frame_pointer        = gen_reg[`EAG_REG_FRM];
	wire [15:0] source_index               = gen_reg[`EAG_REG_SRC];
	wire [15:0] destination_index_register = gen_reg[`EAG_REG_DST];
	wire [15:0] port_number_register       = gen_reg[`EAG_REG_PORT];

	wire [1:0] mode_fld = mode_byte_in[`EAG_MOD_HI:`EAG_MOD_LO];
	wire [2:0] rm_fld   = mode_byte_in[`EAG_RM_HI:`EAG_RM_LO];

	// address composition
	reg  [15:0] disp_val;
	reg  [15:0] base_val;
	reg  [15:0] index_val;
	reg         frame_base;
	reg  [1:0]  seg_pick;
	reg  [15:0] seg_val;
	reg  [15:0] nxt_offset;
	reg  [16:0] offset_sum;

	always @* begin
		disp_val   = `EAG_ZERO16;
		base_val   = `EAG_ZERO16;
		index_val  = `EAG_ZERO16;
		frame_base = 1'b0;
		// eight-bit displacement is sign-extended, sixteen taken whole
		case (mode_fld)
			`EAG_MOD_DISP8: begin
				disp_val = {{8{disp_lo_in[7]}}, disp_lo_in};
			end
			`EAG_MOD_DISP16: begin
				disp_val = {disp_hi_in, disp_lo_in};
			end
			`EAG_MOD_NODISP: begin
				if (rm_fld == `EAG_RM_FRM) begin
					disp_val = {disp_hi_in, disp_lo_in};
				end
			end
			default: begin
				disp_val = `EAG_ZERO16;
			end
		endcase
		// base and index selection per rm field
		case (rm_fld)
			`EAG_RM_BASE_SRC: begin
				base_val  = general_base_register;
				index_val = source_index;
			end
			`EAG_RM_BASE_DST: begin
				base_val  = general_base_register;
				index_val = destination_index_register;
			end
			`EAG_RM_FRM_SRC: begin
				base_val   = stack_frame_pointer;
				index_val  = source_index;
				frame_base = 1'b1;
			end
			`EAG_RM_FRM_DST: begin
				base_val   = stack_frame_pointer;
				index_val  = destination_index_register;
				frame_base = 1'b1;
			end
			`EAG_RM_SRC: begin
				index_val = source_index;
			end
			`EAG_RM_DST: begin
				index_val = destination_index_register;
			end
			`EAG_RM_FRM: begin
				// no-displacement form here is direct addressing
				if (mode_fld != `EAG_MOD_NODISP) begin
					base_val   = stack_frame_pointer;
					frame_base = 1'b1;
				end
			end
			`EAG_RM_BASE: begin
				base_val = general_base_register;
			end
			default: begin
				base_val = `EAG_ZERO16;
			end
		endcase
		// carry beyond bit 15 is dropped so the offset wraps
		offset_sum = {1'b0, disp_val} + {1'b0, base_val} + {1'b0, index_val};
		nxt_offset = offset_sum[15:0];
		// segment choice: override wins, else frame base picks stack
		if (seg_override_in) begin
			seg_pick = seg_override_sel_in;
		end else if (frame_base) begin
			seg_pick = `EAG_SEG_STACK;
		end else begin
			seg_pick = `EAG_SEG_DATA;
		end
		case (seg_pick)
			`EAG_SEG_EXTRA: seg_val = extra_segment_register_in;
			`EAG_SEG_CODE:  seg_val = code_segment_in;
			`EAG_SEG_STACK: seg_val = stack_segment_in;
			default:        seg_val = data_segment_register_in;
		endcase
	end

	// shift segment four places and add the offset, twenty-bit result
	function [19:0] phys_of;
		input [15:0] seg;
		input [15:0] ofs;
		begin
			phys_of = {seg, `EAG_ZERO4} + {`EAG_ZERO4, ofs};
		end
	endfunction

	// string step size and direction
	wire [15:0] str_step = word_in ? `EAG_STEP_WORD : `EAG_STEP_BYTE;
	wire [15:0] nxt_src_idx = direction_flag_in ? (source_index - str_step)
					: (source_index + str_step);
	wire [15:0] nxt_dst_idx = direction_flag_in
					? (destination_index_register - str_step)
					: (destination_index_register + str_step);
	wire [15:0] str_src_seg = seg_override_in ? seg_val
					: data_segment_register_in;

	wire is_mem     = req_in && (op_kind_in == `EAG_OP_MEM);
	wire is_reg     = is_mem && (mode_fld == `EAG_MOD_REG);
	wire is_mem_bus = is_mem && (mode_fld != `EAG_MOD_REG);
	wire is_str     = req_in && (op_kind_in == `EAG_OP_STRING);
	// odd word access needs a second bus cycle
	wire split_word = word_in && nxt_offset[0];

	// output flops; every port is a plain copy of one of these
	reg              done_ff;
	reg  [OFS_W-1:0] operand_offset_ff;
	reg  [PHY_W-1:0] phys_addr_ff;
	reg  [1:0]       seg_sel_ff;
	reg              mem_cycle_req_ff;
	reg  [1:0]       mem_cycle_count_ff;
	reg              reg_only_ff;
	reg  [15:0]      jump_target_ff;
	reg              imm_valid_ff;
	reg  [15:0]      imm_value_ff;
	reg              io_req_ff;
	reg  [15:0]      io_port_ff;
	reg              str_valid_ff;
	reg  [PHY_W-1:0] str_src_phys_ff;
	reg  [PHY_W-1:0] str_dst_phys_ff;
	reg  [15:0]      src_index_next_ff;
	reg  [15:0]      destination_index_register_next_ff;
	reg  [15:0]      signed_operand_ff;
	reg  [3:0]       bcd_high_digit_ff;
	reg  [3:0]       bcd_low_digit_ff;
	reg  [15:0]      ptr_selector_ff;
	reg  [15:0]      ptr_offset_ff;

	assign done_out = done_ff;
	assign operand_offset_out = operand_offset_ff;
	assign phys_addr_out = phys_addr_ff;
	assign seg_sel_out = seg_sel_ff;
	assign mem_cycle_req_out = mem_cycle_req_ff;
	assign mem_cycle_count_out = mem_cycle_count_ff;
	assign reg_only_out = reg_only_ff;
	assign jump_target_out = jump_target_ff;
	assign imm_valid_out = imm_valid_ff;
	assign imm_value_out = imm_value_ff;
	assign io_req_out = io_req_ff;
	assign io_port_out = io_port_ff;
	assign str_valid_out = str_valid_ff;
	assign str_src_phys_out = str_src_phys_ff;
	assign str_dst_phys_out = str_dst_phys_ff;
	assign src_index_next_out = src_index_next_ff;
	assign destination_index_register_next_out =
		destination_index_register_next_ff;
	assign signed_operand_out = signed_operand_ff;
	assign bcd_high_digit_out = bcd_high_digit_ff;
	assign bcd_low_digit_out = bcd_low_digit_ff;
	assign ptr_selector_out = ptr_selector_ff;
	assign ptr_offset_out = ptr_offset_ff;

	always @(posedge clk_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			done_ff                            <= 1'b0;
			operand_offset_ff                  <= {OFS_W{1'b0}};
			phys_addr_ff                       <= {PHY_W{1'b0}};
			seg_sel_ff                         <= `EAG_SEG_DATA;
			mem_cycle_req_ff                   <= 1'b0;
			mem_cycle_count_ff                 <= `EAG_ONE_CYCLE;
			reg_only_ff                        <= 1'b0;
			jump_target_ff                     <= `EAG_ZERO16;
			imm_valid_ff                       <= 1'b0;
			imm_value_ff                       <= `EAG_ZERO16;
			io_req_ff                          <= 1'b0;
			io_port_ff                         <= `EAG_ZERO16;
			str_valid_ff                       <= 1'b0;
			str_src_phys_ff                    <= {PHY_W{1'b0}};
			str_dst_phys_ff                    <= {PHY_W{1'b0}};
			src_index_next_ff                  <= `EAG_ZERO16;
			destination_index_register_next_ff <= `EAG_ZERO16;
			signed_operand_ff                  <= `EAG_ZERO16;
			bcd_high_digit_ff                  <= `EAG_ZERO4;
			bcd_low_digit_ff                   <= `EAG_ZERO4;
			ptr_selector_ff                    <= `EAG_ZERO16;
			ptr_offset_ff                      <= `EAG_ZERO16;
		end else begin
			done_ff          <= req_in;
			mem_cycle_req_ff <= is_mem_bus;
			reg_only_ff      <= is_reg;
			imm_valid_ff     <= req_in && (op_kind_in == `EAG_OP_IMM);
			io_req_ff        <= req_in && ((op_kind_in == `EAG_OP_IO_DIR)
					|| (op_kind_in == `EAG_OP_IO_IND));
			str_valid_ff     <= is_str;
			if (is_mem_bus) begin
				operand_offset_ff  <= nxt_offset;
				phys_addr_ff       <= phys_of(seg_val, nxt_offset);
				seg_sel_ff         <= seg_pick;
				mem_cycle_count_ff <= split_word ? `EAG_TWO_CYCLES
						: `EAG_ONE_CYCLE;
			end
			// register form of a jump takes any general register
			if (is_reg && jump_instruction_in) begin
				jump_target_ff <= gen_reg[rm_fld];
			end
			if (req_in && (op_kind_in == `EAG_OP_IMM)) begin
				imm_value_ff <= word_in ? {disp_hi_in, disp_lo_in}
						: {`EAG_ZERO8, disp_lo_in};
			end
			if (req_in && (op_kind_in == `EAG_OP_IO_DIR)) begin
				io_port_ff <= {`EAG_ZERO8, disp_lo_in};
			end else if (req_in && (op_kind_in == `EAG_OP_IO_IND)) begin
				io_port_ff <= port_number_register;
			end
			if (is_str) begin
				str_src_phys_ff <= phys_of(str_src_seg, source_index);
				str_dst_phys_ff <= phys_of(extra_segment_register_in,
						destination_index_register);
				src_index_next_ff                  <= nxt_src_idx;
				destination_index_register_next_ff <= nxt_dst_idx;
			end
			if (req_in) begin
				// byte operands sign-extend from bit 7
				signed_operand_ff <= word_in ? operand_data_in
						: {(operand_data_in[7] ? `EAG_ONES8 : `EAG_ZERO8),
						operand_data_in[7:0]};
				bcd_high_digit_ff <= operand_data_in[7:4];
				bcd_low_digit_ff  <= operand_data_in[3:0];
				ptr_selector_ff   <= pointer_data_in[31:16];
				ptr_offset_ff     <= pointer_data_in[15:0];
			end
		end
	end

endmodule
`default_nettype wire

/* eag_defs.vh */
// constants for the effective address generator
`ifndef EAG_DEFS_VH
`define EAG_DEFS_VH

// operation kinds presented with a request
`define EAG_OP_MEM      3'h0
`define EAG_OP_IMM      3'h1
`define EAG_OP_IO_DIR   3'h2
`define EAG_OP_IO_IND   3'h3
`define EAG_OP_STRING   3'h4

// addressing-mode byte fields
`define EAG_MOD_HI      7
`define EAG_MOD_LO      6
`define EAG_RM_HI       2
`define EAG_RM_LO       0

// mode field values
`define EAG_MOD_NODISP  2'h0
`define EAG_MOD_DISP8   2'h1
`define EAG_MOD_DISP16  2'h2
`define EAG_MOD_REG     2'h3

// rm field values
`define EAG_RM_BASE_SRC 3'h0
`define EAG_RM_BASE_DST 3'h1
`define EAG_RM_FRM_SRC  3'h2
`define EAG_RM_FRM_DST  3'h3
`define EAG_RM_SRC      3'h4
`define EAG_RM_DST      3'h5
`define EAG_RM_FRM      3'h6
`define EAG_RM_BASE     3'h7

// segment selector codes
`define EAG_SEG_EXTRA   2'h0
`define EAG_SEG_CODE    2'h1
`define EAG_SEG_STACK   2'h2
`define EAG_SEG_DATA    2'h3

// general register slots in the packed register bus
`define EAG_REG_PORT    3'h2
`define EAG_REG_BASE    3'h3
`define EAG_REG_FRM     3'h5
`define EAG_REG_SRC     3'h6
`define EAG_REG_DST     3'h7

// widths and step sizes
`define EAG_SEG_SHIFT   4
`define EAG_STEP_BYTE   16'h0001
`define EAG_STEP_WORD   16'h0002
`define EAG_ZERO16      16'h0000
`define EAG_ZERO8       8'h00
`define EAG_ONES8       8'hff
`define EAG_ZERO4       4'h0
`define EAG_ONE_CYCLE   2'h1
`define EAG_TWO_CYCLES  2'h2

`endif

/* eag_checker_sva.sv */
// concurrent checks on the address generator ports
`timescale 1ns/10ps
`default_nettype none
module eag_checker #(
	parameter OFS_W = 16,
	parameter PHY_W = 20
) (
	input wire logic             clk_in,
	input wire logic             rst_n_in,
	input wire logic             req_in,
	input wire logic [2:0]       op_kind_in,
	input wire logic [7:0]       mode_byte_in,
	input wire logic [7:0]       disp_lo_in,
	input wire logic [7:0]       disp_hi_in,
	input wire logic [127:0]     gen_regs_in,
	input wire logic [15:0]      extra_segment_register_in,
	input wire logic [15:0]      code_segment_in,
	input wire logic [15:0]      stack_segment_in,
	input wire logic [15:0]      data_segment_register_in,
	input wire logic [15:0]      operand_data_in,
	input wire logic [31:0]      pointer_data_in,
	input wire logic             done_out,
	input wire logic [OFS_W-1:0] operand_offset_out,
	input wire logic [PHY_W-1:0] phys_addr_out,
	input wire logic [1:0]       seg_sel_out,
	input wire logic             mem_cycle_req_out,
	input wire logic             reg_only_out,
	input wire logic             imm_valid_out,
	input wire logic             io_req_out,
	input wire logic [15:0]      io_port_out,
	input wire logic             str_valid_out,
	input wire logic [PHY_W-1:0] str_dst_phys_out,
	input wire logic [3:0]       bcd_high_digit_out,
	input wire logic [3:0]       bcd_low_digit_out,
	input wire logic [15:0]      ptr_selector_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [63:0] segs_ff;
	wire         mem_rq = req_in && op_kind_in == 3'h0;
	// segment values seen at the request edge
	always @(posedge clk_in) begin
		segs_ff <= {data_segment_register_in, stack_segment_in,
			code_segment_in, extra_segment_register_in};
	end
	done_after_req_a: assert property (req_in |=> done_out)
		else $error("no done after request");
	mem_cycle_a: assert property (mem_rq && mode_byte_in[7:6] != 2'h3
		|=> mem_cycle_req_out && !reg_only_out) else $error("no bus cycle");
	reg_only_a: assert property (mem_rq && mode_byte_in[7:6] == 2'h3
		|=> reg_only_out && !mem_cycle_req_out) else $error("reg op on bus");
	imm_no_bus_a: assert property (req_in && op_kind_in == 3'h1
		|=> imm_valid_out && !mem_cycle_req_out) else $error("imm on bus");
	io_direct_a: assert property (req_in && op_kind_in == 3'h2 |=>
		io_port_out == {8'h00, $past(disp_lo_in)}) else $error("direct port");
	io_indirect_a: assert property (req_in && op_kind_in == 3'h3 |=>
		io_port_out == $past(gen_regs_in[47:32])) else $error("indirect port");
	direct_offset_a: assert property (mem_rq
		&& {mode_byte_in[7:6], mode_byte_in[2:0]} == 5'h06 |=>
		operand_offset_out == {$past(disp_hi_in), $past(disp_lo_in)})
		else $error("direct offset");
	phys_sum_a: assert property (mem_cycle_req_out |->
		phys_addr_out == {segs_ff[seg_sel_out*16 +: 16], 4'h0}
		+ {4'h0, operand_offset_out}) else $error("physical address sum");
	string_dst_a: assert property (req_in && op_kind_in == 3'h4 |=>
		str_dst_phys_out == {$past(extra_segment_register_in), 4'h0}
		+ {4'h0, $past(gen_regs_in[127:112])}) else $error("string dest");
	bcd_ptr_a: assert property (req_in |=>
		{bcd_high_digit_out, bcd_low_digit_out} == $past(operand_data_in[7:0])
		&& ptr_selector_out == $past(pointer_data_in[31:16]))
		else $error("data type split");
endmodule
`default_nettype wire

/* eag_bus_dev.sv */
// memory and port device model feeding operand data back to the core
`timescale 1ns/10ps
`default_nettype none
module eag_bus_dev (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        mem_req_in,
	input  wire logic [19:0] addr_in,
	input  wire logic        io_req_in,
	input  wire logic [15:0] port_in,
	output var  logic [15:0] rd_data_out,
	output var  logic [31:0] ptr_data_out
);
	// answers at the physical address; a released bus toggles every cycle
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= 16'h0000;
			ptr_data_out <= 32'h0000_0000;
		end else if (mem_req_in) begin
			rd_data_out <= addr_in[15:0] ^ {addr_in[19:16], 12'h5a3};
			ptr_data_out <= {addr_in[19:4], addr_in[15:0]};
		end else if (io_req_in) begin
			rd_data_out <= port_in;
			ptr_data_out <= {port_in, ~port_in};
		end else begin
			rd_data_out <= ~rd_data_out;
			ptr_data_out <= ~ptr_data_out;
		end
	end
endmodule
`default_nettype wire

/* tb_top.sv */
// testbench: random requests, predicted results compared at done
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [4:0]  p;
		logic [2:0]  k;
		logic [71:0] v;
		logic [23:0] d;
		logic [31:0] q;
	} eag_note_t;
	logic         clk_in = 1'b0, rst_n_in = 1'b0, req_in = 1'b0;
	logic [2:0]   op_kind_in = 3'h0;
	logic [7:0]   mode_byte_in = 8'h00, disp_lo_in = 8'h00, disp_hi_in = 8'h00;
	logic         word_in = 1'b0, jump_instruction_in = 1'b0;
	logic         seg_override_in = 1'b0, direction_flag_in = 1'b0;
	logic [1:0]   seg_override_sel_in = 2'h0;
	logic [127:0] gen_regs_in = 128'h0;
	logic [15:0]  extra_segment_register_in = 16'h0000, code_segment_in = 16'h0000;
	logic [15:0]  stack_segment_in = 16'h0000, data_segment_register_in = 16'h0000;
	wire  [15:0]  operand_data_in, operand_offset_out, jump_target_out;
	wire  [15:0]  imm_value_out, io_port_out, src_index_next_out;
	wire  [15:0]  destination_index_register_next_out, signed_operand_out;
	wire  [15:0]  ptr_selector_out, ptr_offset_out;
	wire  [31:0]  pointer_data_in;
	wire  [19:0]  phys_addr_out, str_src_phys_out, str_dst_phys_out;
	wire  [1:0]   seg_sel_out, mem_cycle_count_out;
	wire  [3:0]   bcd_high_digit_out, bcd_low_digit_out;
	wire          done_out, mem_cycle_req_out, reg_only_out, imm_valid_out;
	wire          io_req_out, str_valid_out;
	int           n_fail = 0, n_checks = 0, i, seed;
	eag_note_t    notes[$], nt_m;
	wire [4:0]  pulses = {mem_cycle_req_out, reg_only_out, imm_valid_out,
		io_req_out, str_valid_out};
	wire [23:0] dt = {signed_operand_out, bcd_high_digit_out, bcd_low_digit_out};
	wire [23:0] memv = {phys_addr_out, seg_sel_out, mem_cycle_count_out};
	wire [71:0] strv = {str_src_phys_out, str_dst_phys_out, src_index_next_out,
		destination_index_register_next_out};
	eag_effective_address_generator uut (.*);
	eag_bus_dev dev (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.mem_req_in   (mem_cycle_req_out),
		.addr_in      (phys_addr_out),
		.io_req_in    (io_req_out),
		.port_in      (io_port_out),
		.rd_data_out  (operand_data_in),
		.ptr_data_out (pointer_data_in)
	);
	initial forever #2.5 clk_in = ~clk_in;
	function automatic logic [15:0] gr(input logic [2:0] n);
		gr = gen_regs_in[n*16 +: 16];
	endfunction
	function automatic logic [15:0] seg_v(input logic [1:0] s);
		seg_v = s[1] ? (s[0] ? data_segment_register_in : stack_segment_in)
			: (s[0] ? code_segment_in : extra_segment_register_in);
	endfunction
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic send(input logic [2:0] k, input logic [7:0] m);
		eag_note_t   nt;
		logic [15:0] dsp, ofs, stp, od;
		logic [1:0]  sg;
		logic        fr;
		@(negedge clk_in);
		req_in = 1'b1;
		op_kind_in = k;
		mode_byte_in = m;
		{disp_hi_in, disp_lo_in, word_in, jump_instruction_in, seg_override_in,
			direction_flag_in, seg_override_sel_in} = 22'($urandom);
		gen_regs_in = {$urandom, $urandom, $urandom, $urandom};
		{extra_segment_register_in, code_segment_in} = $urandom;
		{stack_segment_in, data_segment_register_in} = $urandom;
		od = operand_data_in;
		nt.d = {word_in ? od : {{8{od[7]}}, od[7:0]}, od[7:0]};
		nt.q = pointer_data_in;
		nt.k = 3'h5;
		nt.p = 5'h00;
		nt.v = 72'h0;
		dsp = (m[7:6] == 2'h1) ? {{8{disp_lo_in[7]}}, disp_lo_in}
			: (m[7:6] == 2'h2 || {m[7:6], m[2:0]} == 5'h06)
			? {disp_hi_in, disp_lo_in} : 16'h0000;
		fr = m[2:1] == 2'h1 || (m[2:0] == 3'h6 && m[7:6] != 2'h0);
		ofs = dsp;
		if (m[7:6] != 2'h0 || m[2:0] != 3'h6) begin
			if (m[2:1] == 2'h0 || m[2:0] == 3'h7) ofs = ofs + gr(3'h3);
			if (fr) ofs = ofs + gr(3'h5);
			if (m[2:0] < 3'h6) ofs = ofs + gr({2'h3, m[0]});
		end
		sg = seg_override_in ? seg_override_sel_in : (fr ? 2'h2 : 2'h3);
		stp = word_in ? 16'h0002 : 16'h0001;
		case (k)
		3'h0: if (m[7:6] == 3'h3) begin
			nt.p = 5'h08;
			if (jump_instruction_in) begin
				nt.k = 3'h4;
				nt.v[15:0] = gr(m[2:0]);
			end
		end else begin
			nt.k = 3'h0;
			nt.p = 5'h10;
			nt.v[39:0] = {ofs, {seg_v(sg), 4'h0} + {4'h0, ofs}, sg,
				(word_in & ofs[0]) ? 2'h2 : 2'h1};
		end
		3'h1: begin
			nt.k = 3'h1;
			nt.p = 5'h04;
			nt.v[15:0] = word_in ? {disp_hi_in, disp_lo_in} : {8'h00, disp_lo_in};
		end
		3'h2, 3'h3: begin
			nt.k = 3'h2;
			nt.p = 5'h02;
			nt.v[15:0] = k[0] ? gr(3'h2) : {8'h00, disp_lo_in};
		end
		3'h4: begin
			nt.k = 3'h3;
			nt.p = 5'h01;
			nt.v = {{seg_v(seg_override_in ? seg_override_sel_in : 2'h3), 4'h0}
				+ {4'h0, gr(3'h6)}, {extra_segment_register_in, 4'h0}
				+ {4'h0, gr(3'h7)}, direction_flag_in ? gr(3'h6) - stp
				: gr(3'h6) + stp, direction_flag_in ? gr(3'h7) - stp : gr(3'h7) + stp};
		end
		default: ;
		endcase
		notes.push_back(nt);
	endtask
	always @(negedge clk_in) begin
		if (done_out === 1'b1 && notes.size() == 0) check(1'b0, "spurious done");
		else if (done_out === 1'b1) begin
			nt_m = notes.pop_front();
			check(pulses === nt_m.p, "pulse set");
			check(dt === nt_m.d, "data type");
			check({ptr_selector_out, ptr_offset_out} === nt_m.q, "pointer");
			case (nt_m.k)
			3'h0: begin
				check(operand_offset_out === nt_m.v[39:24], "ofs");
				check(memv === nt_m.v[23:0], "phys");
			end
			3'h1: check(imm_value_out === nt_m.v[15:0], "imm");
			3'h2: check(io_port_out === nt_m.v[15:0], "port");
			3'h3: check(strv === nt_m.v, "string");
			3'h4: check(jump_target_out === nt_m.v[15:0], "jump");
			default: ;
			endcase
		end
	end
	initial begin
		seed = $urandom(32'h6639_7e9e);
		repeat (16) @(negedge clk_in);
		check(seg_sel_out === 2'h3 && mem_cycle_count_out === 2'h1, "reset");
		rst_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		for (i = 0; i < 256; i++) send(3'h0, i[7:0]);
		$display("test all addressing bytes done");
		for (i = 0; i < 400; i++) send(3'($urandom), 8'($urandom));
		$display("test random kinds done");
		@(negedge clk_in) req_in = 1'b0;
		repeat (4) @(negedge clk_in);
		check(notes.size() == 0, "missing done");
		finish_test;
	end
	initial begin
		#20000;
		check(1'b0, "watchdog expired");
		finish_test;
	end
endmodule
bind eag_effective_address_generator eag_checker #(
	.OFS_W (OFS_W),
	.PHY_W (PHY_W)
) chk (.*);
`default_nettype wire
